/* File: ctto_chk.sv */
// Port checker for the transfer, test and trap unit
`timescale 1ns/1ps
module ctto_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] mem_rdata,
  input wire logic instr_done,
  input wire logic [15:0] sp_o,
  input wire logic [7:0] acc_o,
  input wire logic [15:0] index_o,
  input wire logic [7:0] flags_o
);
  logic f_q;
  logic [7:0] a_q;
  logic [7:0] c_q;
  logic [15:0] s_q;
  logic [15:0] x_q;
  logic [7:0] op;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Opcode cycle follows reset or retirement; copies of last cycle's registers
  always_ff @(posedge clk) begin
    f_q <= sys_rst | instr_done;
    a_q <= acc_o;
    c_q <= flags_o;
    s_q <= sp_o;
    x_q <= index_o;
  end
  // Opcode only meaningful in the fetch cycle
  assign op = f_q ? mem_rdata : 8'h00;
  trap_len_a: assert property (op == 8'h83 |-> (!instr_done) [*8] ##1 instr_done)
    else $error("trap length wrong");
  trap_end_a: assert property (op == 8'h83 |-> ##9 flags_o[3] &&
    sp_o == $past(sp_o, 9) - 16'h0005)
    else $error("trap end state wrong");
  acc_flags_a: assert property (op == 8'h84 |=> instr_done && flags_o == a_q)
    else $error("acc to flags wrong");
  acc_x_a: assert property (op == 8'h97 |-> instr_done ##1
    index_o == {x_q[15:8], a_q} && flags_o == c_q)
    else $error("acc to index wrong");
  flags_acc_a: assert property (op == 8'h85 |-> instr_done ##1
    acc_o == c_q && flags_o == c_q)
    else $error("flags to acc wrong");
  test_acc_a: assert property (op == 8'h4D |-> instr_done ##1
    flags_o == {1'b0, c_q[6:3], a_q[7], a_q == 8'h00, c_q[0]})
    else $error("acc test flags wrong");
  sp_x_a: assert property (op == 8'h95 |=> instr_done && index_o == s_q + 16'h0001)
    else $error("sp to index wrong");
  x_sp_a: assert property (op == 8'h94 |=> instr_done && sp_o == x_q - 16'h0001)
    else $error("index to sp wrong");
  page_two_a: assert property (op == 8'h9E ##1 mem_rdata == 8'h6D |->
    !instr_done ##2 instr_done)
    else $error("second page length wrong");
  trap_c: cover property (op == 8'h83);
  page_c: cover property (op == 8'h9E);
  test_c: cover property (op == 8'h3D);
endmodule : ctto_chk
bind ctto_core ctto_chk i_ctto_chk (.clk(clk), .sys_rst(sys_rst), .mem_rdata(mem_rdata),
  .instr_done(instr_done), .sp_o(sp_o), .acc_o(acc_o), .index_o(index_o), .flags_o(flags_o));

/* File: ctto_core.sv */
// Execution of the trap, register transfer and test instructions of the core
`timescale 1ns/1ps
`include "ctto_defines.svh"

module ctto_core #(
  parameter logic [15:0] RESET_PC = 16'h0000,
  parameter logic [15:0] TRAP_VECTOR = 16'hFFFC
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] mem_wdata,
  output logic mem_re,
  output logic mem_we,
  output logic instr_done,
  output logic illegal_op,
  output logic [15:0] pc_o,
  output logic [15:0] sp_o,
  output logic [7:0] acc_o,
  output logic [15:0] index_o,
  output logic [7:0] flags_o
);

  ctto_pkg::ctto_state_t state_q, state_d;
  ctto_pkg::ctto_tmode_t tmode_q, tmode_d;
  logic [2:0] cnt_q, cnt_d;
  logic [15:0] ea_q, ea_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] hx_q, hx_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] flg_q, flg_d;
  logic [7:0] test_src;
  logic [7:0] test_flags;

  // Base plus unsigned byte offset, shared by both offset forms
  function automatic logic [15:0] ctto_offset_add(input logic [15:0] base, input logic [7:0] off);
    ctto_offset_add = base + {8'h00, off};
  endfunction : ctto_offset_add

  // Byte pushed in each trap slot, lowest program byte first
  function automatic logic [7:0] ctto_push_byte(input logic [2:0] slot, input logic [15:0] pc,
                                                input logic [7:0] x, input logic [7:0] a,
                                                input logic [7:0] flg);
    case (slot)
      3'h0: ctto_push_byte = pc[7:0];
      3'h1: ctto_push_byte = pc[15:8];
      3'h2: ctto_push_byte = x;
      3'h3: ctto_push_byte = a;
      default: ctto_push_byte = flg;
    endcase
  endfunction : ctto_push_byte

  // Test operand: memory byte in the read cycle, else the register named by the opcode
  always_comb begin
    if (state_q == ctto_pkg::ST_READ) begin
      test_src = mem_rdata;
    end else if (mem_rdata == `CTTO_OP_TEST_X) begin
      test_src = hx_q[7:0];
    end else begin
      test_src = acc_q;
    end
  end

  ctto_flag_eval u_flag_eval (
    .operand(test_src),
    .flags_in(flg_q),
    .flags_out(test_flags)
  );

  // Sequencer and datapath next values; memory reads answer in the same cycle
  always_comb begin
    state_d = state_q;
    tmode_d = tmode_q;
    cnt_d = cnt_q;
    ea_d = ea_q;
    pc_d = pc_q;
    sp_d = sp_q;
    hx_d = hx_q;
    acc_d = acc_q;
    flg_d = flg_q;
    mem_addr = pc_q;
    mem_wdata = 8'h00;
    mem_re = 1'b0;
    mem_we = 1'b0;
    instr_done = 1'b0;
    illegal_op = 1'b0;
    unique case (state_q)
      ctto_pkg::ST_FETCH: begin
        mem_re = 1'b1;
        pc_d = pc_q + 16'h0001;
        unique case (mem_rdata)
          `CTTO_OP_SWTRAP: begin
            cnt_d = 3'h0;
            state_d = ctto_pkg::ST_PUSH;
          end
          `CTTO_OP_A2FLG: begin
            flg_d = acc_q;
            state_d = ctto_pkg::ST_WAIT;
          end
          `CTTO_OP_A2X: begin
            hx_d[7:0] = acc_q;
            instr_done = 1'b1;
          end
          `CTTO_OP_FLG2A: begin
            acc_d = flg_q;
            instr_done = 1'b1;
          end
          `CTTO_OP_X2A: begin
            acc_d = hx_q[7:0];
            instr_done = 1'b1;
          end
          `CTTO_OP_SP2HX: begin
            hx_d = sp_q + 16'h0001;
            state_d = ctto_pkg::ST_WAIT;
          end
          `CTTO_OP_HX2SP: begin
            sp_d = hx_q - 16'h0001;
            state_d = ctto_pkg::ST_WAIT;
          end
          `CTTO_OP_TEST_A, `CTTO_OP_TEST_X: begin
            flg_d = test_flags;
            instr_done = 1'b1;
          end
          `CTTO_OP_TEST_DIR: begin
            tmode_d = ctto_pkg::TM_DIRECT;
            state_d = ctto_pkg::ST_OPER;
          end
          `CTTO_OP_TEST_IXO: begin
            tmode_d = ctto_pkg::TM_INDEX_OFFSET8;
            state_d = ctto_pkg::ST_OPER;
          end
          `CTTO_OP_TEST_IXP: begin
            ea_d = hx_q;
            state_d = ctto_pkg::ST_READ;
          end
          `CTTO_OP_PAGE2: begin
            state_d = ctto_pkg::ST_PAGE2;
          end
          default: begin
            // Opcodes outside this group retire as a one-cycle no-op
            illegal_op = 1'b1;
            instr_done = 1'b1;
          end
        endcase
      end
      ctto_pkg::ST_PAGE2: begin
        // Second byte decoded in the second page only
        mem_re = 1'b1;
        pc_d = pc_q + 16'h0001;
        if (mem_rdata == `CTTO_OP2_TEST_SPO) begin
          tmode_d = ctto_pkg::TM_STACK_OFFSET8;
          state_d = ctto_pkg::ST_OPER;
        end else begin
          illegal_op = 1'b1;
          instr_done = 1'b1;
          state_d = ctto_pkg::ST_FETCH;
        end
      end
      ctto_pkg::ST_OPER: begin
        // Address or offset byte follows the opcode
        mem_re = 1'b1;
        pc_d = pc_q + 16'h0001;
        unique case (tmode_q)
          ctto_pkg::TM_DIRECT: ea_d = {8'h00, mem_rdata};
          ctto_pkg::TM_INDEX_OFFSET8: ea_d = ctto_offset_add(hx_q, mem_rdata);
          ctto_pkg::TM_STACK_OFFSET8: ea_d = ctto_offset_add(sp_q, mem_rdata);
        endcase
        state_d = ctto_pkg::ST_READ;
      end
      ctto_pkg::ST_READ: begin
        mem_re = 1'b1;
        mem_addr = ea_q;
        flg_d = test_flags;
        instr_done = 1'b1;
        state_d = ctto_pkg::ST_FETCH;
      end
      ctto_pkg::ST_WAIT: begin
        // Second cycle of the two-cycle transfers
        instr_done = 1'b1;
        state_d = ctto_pkg::ST_FETCH;
      end
      ctto_pkg::ST_PUSH: begin
        // Stack pointer points at the free byte, so write then decrement
        mem_we = 1'b1;
        mem_addr = sp_q;
        mem_wdata = ctto_push_byte(cnt_q, pc_q, hx_q[7:0], acc_q, flg_q);
        sp_d = sp_q - 16'h0001;
        if (cnt_q == `CTTO_TRAP_LAST_PUSH) begin
          cnt_d = 3'h0;
          state_d = ctto_pkg::ST_VEC;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      ctto_pkg::ST_VEC: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h0) begin
          flg_d[`CTTO_FLAG_I] = 1'b1;
        end else if (cnt_q == 3'h1) begin
          mem_re = 1'b1;
          mem_addr = TRAP_VECTOR;
          pc_d[15:8] = mem_rdata;
        end else begin
          mem_re = 1'b1;
          mem_addr = TRAP_VECTOR + 16'h0001;
          pc_d[7:0] = mem_rdata;
          cnt_d = 3'h0;
          instr_done = 1'b1;
          state_d = ctto_pkg::ST_FETCH;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ctto_pkg::ST_FETCH;
      tmode_q <= ctto_pkg::TM_DIRECT;
      cnt_q <= 3'h0;
      ea_q <= `CTTO_RST_WORD;
    end else begin
      state_q <= state_d;
      tmode_q <= tmode_d;
      cnt_q <= cnt_d;
      ea_q <= ea_d;
    end
  end

  // Program counter and stack pointer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_q <= RESET_PC;
      sp_q <= `CTTO_RST_SP;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
    end
  end

  // Accumulator, index pair and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= `CTTO_RST_BYTE;
      hx_q <= `CTTO_RST_WORD;
      flg_q <= `CTTO_RST_FLG;
    end else begin
      acc_q <= acc_d;
      hx_q <= hx_d;
      flg_q <= flg_d;
    end
  end

  // Register views for observers
  assign pc_o = pc_q;
  assign sp_o = sp_q;
  assign acc_o = acc_q;
  assign index_o = hx_q;
  assign flags_o = flg_q;

endmodule : ctto_core

/* File: ctto_defines.svh */
// Opcodes, flag positions, reset values and cycle counts of the transfer, test and trap unit
`ifndef CTTO_DEFINES_SVH
`define CTTO_DEFINES_SVH

// First-page opcodes
`define CTTO_OP_SWTRAP 8'h83
`define CTTO_OP_A2FLG 8'h84
`define CTTO_OP_FLG2A 8'h85
`define CTTO_OP_A2X 8'h97
`define CTTO_OP_X2A 8'h9F
`define CTTO_OP_SP2HX 8'h95
`define CTTO_OP_HX2SP 8'h94
`define CTTO_OP_TEST_DIR 8'h3D
`define CTTO_OP_TEST_A 8'h4D
`define CTTO_OP_TEST_X 8'h5D
`define CTTO_OP_TEST_IXO 8'h6D
`define CTTO_OP_TEST_IXP 8'h7D
// Prefix byte and its second-page opcode
`define CTTO_OP_PAGE2 8'h9E
`define CTTO_OP2_TEST_SPO 8'h6D

// Flag register bit positions
`define CTTO_FLAG_V 7
`define CTTO_FLAG_H 4
`define CTTO_FLAG_I 3
`define CTTO_FLAG_N 2
`define CTTO_FLAG_Z 1
`define CTTO_FLAG_C 0

// Reset values
`define CTTO_RST_SP 16'h00FF
`define CTTO_RST_FLG 8'h68
`define CTTO_RST_BYTE 8'h00
`define CTTO_RST_WORD 16'h0000

// Trap sequencing counts
`define CTTO_TRAP_PUSHES 3'h5
`define CTTO_TRAP_LAST_PUSH 3'h4
`define CTTO_TRAP_CYCLES 9

`endif

/* File: ctto_flag_eval.sv */
// Flag update of the test for negative or zero
`timescale 1ns/1ps
`include "ctto_defines.svh"

module ctto_flag_eval (
  input wire logic [7:0] operand,
  input wire logic [7:0] flags_in,
  output logic [7:0] flags_out
);

  // Operand minus zero: N and Z from the byte, V cleared, rest kept
  always_comb begin
    flags_out = flags_in;
    flags_out[`CTTO_FLAG_N] = operand[7];
    flags_out[`CTTO_FLAG_Z] = (operand == 8'h00);
    flags_out[`CTTO_FLAG_V] = 1'b0;
  end

endmodule : ctto_flag_eval

/* File: ctto_mem_model.sv */
// Program and stack memory model facing the core bus
`timescale 1ns/1ps
module ctto_mem_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_re,
  input wire logic mem_we
);
  logic [7:0] mem_q [0:65535];
  // Same-cycle read; an idle bus shows the inverted cell so stale data never passes
  assign mem_rdata = mem_re ? mem_q[mem_addr] : ~mem_q[mem_addr];
  // Byte write at the strobe edge; plain always so the bench may preload cells
  always @(posedge clk) begin
    if (mem_we) begin
      mem_q[mem_addr] <= mem_wdata;
    end
  end
endmodule : ctto_mem_model

/* File: ctto_pkg.sv */
// Types shared by the transfer, test and trap unit
package ctto_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_PAGE2,
    ST_OPER,
    ST_READ,
    ST_WAIT,
    ST_PUSH,
    ST_VEC
  } ctto_state_t;

  // Operand address forms of the memory test
  typedef enum logic [1:0] {
    TM_DIRECT,
    TM_INDEX_OFFSET8,
    TM_STACK_OFFSET8
  } ctto_tmode_t;

endpackage : ctto_pkg

/* File: tb_top.sv */
// Self-checking bench for the transfer, test and trap unit
`timescale 1ns/1ps
`define CK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module tb_top;
  logic clk;
  logic sys_rst;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  logic [7:0] mem_wdata;
  logic mem_re;
  logic mem_we;
  logic instr_done;
  logic illegal_op;
  logic bad_op_q;
  logic [15:0] pc_o;
  logic [15:0] sp_o;
  logic [7:0] acc_o;
  logic [15:0] index_o;
  logic [7:0] flags_o;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  ctto_core i_ctto_core (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_we(mem_we),
    .instr_done(instr_done), .illegal_op(illegal_op), .pc_o(pc_o), .sp_o(sp_o), .acc_o(acc_o),
    .index_o(index_o), .flags_o(flags_o));
  ctto_mem_model i_ctto_mem_model (.clk(clk), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_we(mem_we));
  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Illegal flag of the cycle that just ended; a pulse is gone by the time checks run
  always @(posedge clk) begin
    bad_op_q <= illegal_op;
  end
  // Hang guard; a whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // Memory is only touched while the core sits in reset
  task automatic put(input logic [15:0] a, input logic [7:0] p [$]);
    @(posedge clk);
    #1 sys_rst = 1'b1;
    foreach (p[i]) i_ctto_mem_model.mem_q[a + i] = p[i];
  endtask : put
  task automatic go;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
  endtask : go
  task automatic step(input int n);
    repeat (n) @(posedge clk iff instr_done === 1'b1);
    #1;
  endtask : step
  // Trap with distinct accumulator and flag values on the stack
  task automatic t_trap;
    logic [7:0] pu [5] = '{8'h0A, 8'h00, 8'h04, 8'h04, 8'h02};
    put(16'h0000, '{8'h95, 8'h9F, 8'h84, 8'h3D, 8'h10, 8'h85, 8'h97, 8'h3D, 8'h11, 8'h83});
    put(16'h0010, '{8'h80, 8'h00});
    go();
    step(8);
    `CK("pc", 16'h0100, pc_o)
    `CK("sp", 16'h00FA, sp_o)
    `CK("flags", 8'h0A, flags_o)
    foreach (pu[i]) `CK("push", pu[i], i_ctto_mem_model.mem_q[16'h00FF - i])
  endtask : t_trap
  // Transfer chain after a trap has moved the stack pointer
  task automatic t_xfer;
    put(16'h0000, '{8'h83});
    put(16'h0100, '{8'h95, 8'h9F, 8'h84, 8'h7D, 8'h85, 8'h97, 8'h94});
    go();
    step(2);
    `CK("index", 16'h00FB, index_o)
    step(1);
    `CK("acc", 8'hFB, acc_o)
    step(1);
    `CK("flags", 8'hFB, flags_o)
    step(1);
    `CK("flags", 8'h79, flags_o)
    step(1);
    `CK("acc", 8'h79, acc_o)
    step(1);
    `CK("index", 16'h0079, index_o)
    step(1);
    `CK("sp", 16'h0078, sp_o)
    `CK("flags", 8'h79, flags_o)
  endtask : t_xfer
  // Every test form except the plain indexed one, alternating zero and negative, then a bad second-page byte
  task automatic t_test;
    logic [7:0] fl [6] = '{8'h6A, 8'h6C, 8'h6A, 8'h6C, 8'h6A, 8'h6A};
    put(16'h0000, '{8'h3D, 8'h20, 8'h6D, 8'h21, 8'h4D, 8'h9E, 8'h6D, 8'h10, 8'h5D, 8'h9E, 8'h00});
    put(16'h0020, '{8'h00, 8'h80});
    put(16'h010F, '{8'h80});
    go();
    foreach (fl[i]) begin
      step(1);
      `CK("test flags", fl[i], flags_o)
      `CK("illegal", 1'(i == 5), bad_op_q)
    end
    `CK("pc", 16'h000B, pc_o)
  endtask : t_test
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    for (int i = 0; i < 65536; i++) i_ctto_mem_model.mem_q[i] = 8'h00;
    i_ctto_mem_model.mem_q[16'hFFFC] = 8'h01;
    t_trap();
    t_xfer();
    t_test();
    close_out();
  end
endmodule : tb_top
